// file: rtl/arf_pkg.sv
// constants, types and register map of the converter result/reference control block
// assumes an APB master in front and a converter core that signals completion
package arf_pkg;

	////////////////////////////////////////////////////////////////////////////
	// register byte offsets on the bus
	localparam logic [11:0] ARF_OFS_SELECT = 12'h07C;
	localparam logic [11:0] ARF_OFS_CONTROL = 12'h080;
	localparam logic [11:0] ARF_OFS_RES_LOW = 12'h084;
	localparam logic [11:0] ARF_OFS_RES_HIGH = 12'h088;
	localparam logic [11:0] ARF_OFS_IRQ_STAT = 12'h08C;
	localparam logic [11:0] ARF_OFS_IRQ_MASK = 12'h090;

	// select register layout and reset
	localparam int ARF_REF_MSB = 7;
	localparam int ARF_REF_LSB = 6;
	localparam int ARF_ALIGN_BIT = 5;
	localparam int ARF_CHAN_MSB = 4;
	localparam logic [7:0] ARF_SELECT_RESET = 8'h00;

	// control register bits: start on write, busy on read
	localparam int ARF_CTRL_START_BIT = 0;
	localparam int ARF_CTRL_BUSY_BIT = 1;

	// status/mask bit for the completion event
	localparam int ARF_IRQ_DONE_BIT = 0;
	localparam logic [0:0] ARF_IRQ_RESET = 1'h0;

	// result geometry
	localparam int ARF_RES_W = 10;
	localparam int ARF_DATA_W = 16;
	localparam int ARF_LEFT_SHIFT = ARF_DATA_W - ARF_RES_W;

	// channel codes that choose a differential pair
	localparam logic [4:0] ARF_DIFF_FIRST = 5'h08;
	localparam logic [4:0] ARF_DIFF_LAST = 5'h1D;

	// reference encodings
	localparam logic [1:0] ARF_REF_EXT_PIN = 2'h0;
	localparam logic [1:0] ARF_REF_SUPPLY = 2'h1;
	localparam logic [1:0] ARF_REF_INT_1V1 = 2'h2;
	localparam logic [1:0] ARF_REF_INT_2V56 = 2'h3;

	typedef enum logic [0:0] {ARF_IDLE, ARF_BUSY} arf_state_e;

	// captured conversion: kind and raw core code
	typedef struct packed {
		logic diff;
		logic [ARF_RES_W-1:0] code;
	} arf_result_s;

	// reference and channel as handed to the analog side
	typedef struct packed {
		logic [1:0] reference_field;
		logic [ARF_CHAN_MSB:0] channel_gain_field;
	} arf_route_s;

endpackage

// file: rtl/arf_route_buffer.sv
// buffered reference/channel route toward the analog core
// assumes lock is high for the whole of a conversion
`timescale 1ns/1ps
module arf_route_buffer import arf_pkg::*; (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// software copy and conversion lock
	input wire arf_route_s written,
	input wire logic lock,
	// route seen by the core
	output arf_route_s active
);

	arf_route_s next_active;

	// follow the written copy only while no conversion runs
	always_comb begin
		next_active = active;
		if (!lock) begin
			next_active = written;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			// reset route is the select reset value without its alignment bit
			active.reference_field <= ARF_SELECT_RESET[ARF_REF_MSB:ARF_REF_LSB];
			active.channel_gain_field <= ARF_SELECT_RESET[ARF_CHAN_MSB:0];
		end else begin
			active <= next_active;
		end
	end

endmodule

// file: rtl/arf_result_format.sv
// encoding and alignment of a stored result into the 16-bit data word
// purely combinational so alignment changes show at once
`timescale 1ns/1ps
module arf_result_format import arf_pkg::*; (
	// stored result and alignment choice
	input wire arf_result_s result,
	input wire logic left_align,
	// data register image
	output logic [ARF_DATA_W-1:0] data
);

	logic [ARF_RES_W-1:0] coded;

	// core gives offset binary for pairs; flipping the msb gives two's complement
	always_comb begin
		coded = result.code;
		if (result.diff) begin
			coded[ARF_RES_W-1] = ~result.code[ARF_RES_W-1];
		end
		if (left_align) begin
			data = {coded, {ARF_LEFT_SHIFT{1'b0}}};
		end else begin
			data = {{ARF_LEFT_SHIFT{1'b0}}, coded};
		end
	end

endmodule

// file: rtl/arf_converter_ctrl.sv
// top: APB register file, conversion sequencing, result hold and interrupt
// assumes the core pulses conv_done once per conv_start with conv_code valid then
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
module arf_converter_ctrl import arf_pkg::*; #(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// converter core
	output logic conv_start,
	output arf_route_s conv_route,
	input wire logic conv_done,
	input wire logic [ARF_RES_W-1:0] conv_code,
	// interrupt
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////
	// elaboration check: the map needs 12 address bits
	if (ADDR_W < 12) begin : g_bad_addr
		$error("ADDR_W must be at least 12");
	end

	// the result must fit the data word and reach into the high byte, or the sign bit is lost
	if (ARF_RES_W > ARF_DATA_W || ARF_RES_W <= ARF_DATA_W / 2) begin : g_bad_geom
		$error("result width does not fit the data word");
	end

	////////////////////////////////////////////////////////////////////////////
	// declarations
	logic [7:0] conversion_input_select;
	logic [7:0] next_select;
	arf_state_e state;
	arf_state_e next_state;
	logic next_conv_start;
	arf_result_s result;
	arf_result_s next_result;
	arf_result_s pending;
	arf_result_s next_pending;
	logic pending_valid;
	logic next_pending_valid;
	logic read_lock;
	logic next_read_lock;
	logic [0:0] irq_status;
	logic [0:0] next_irq_status;
	logic [0:0] irq_mask;
	logic [0:0] next_irq_mask;
	logic next_irq;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic access;
	logic wr_en;
	logic rd_en;
	logic [11:0] addr;
	logic mapped;
	logic start_req;
	logic done_diff;
	logic update_now;
	logic low_take;
	logic [ARF_DATA_W-1:0] data_word;
	arf_route_s written_route;
	arf_route_s active_route;

	////////////////////////////////////////////////////////////////////////////
	// bus decode: answer on the second access cycle
	// only the low 12 address bits decode; higher bits alias the map
	assign addr = paddr[11:0];
	assign access = psel && penable && pready;
	assign wr_en = access && pwrite;
	assign rd_en = access && !pwrite;
	assign mapped = (addr == ARF_OFS_SELECT) || (addr == ARF_OFS_CONTROL) ||
		(addr == ARF_OFS_RES_LOW) || (addr == ARF_OFS_RES_HIGH) ||
		(addr == ARF_OFS_IRQ_STAT) || (addr == ARF_OFS_IRQ_MASK);

	// software copy of route fields
	assign written_route = {conversion_input_select[ARF_REF_MSB:ARF_REF_LSB],
		conversion_input_select[ARF_CHAN_MSB:0]};

	// start honoured only while idle; a start during a conversion is dropped
	assign start_req = wr_en && (addr == ARF_OFS_CONTROL) && pwdata[ARF_CTRL_START_BIT] && (state == ARF_IDLE);

	// pair kind follows the channel that was locked for this conversion
	assign done_diff = (active_route.channel_gain_field >= ARF_DIFF_FIRST) &&
		(active_route.channel_gain_field <= ARF_DIFF_LAST);

	// a low read locks from the cycle its byte is captured, so a completion landing
	// between capture and answer is parked instead of splitting the byte pair
	assign low_take = psel && penable && !pready && !pwrite && (addr == ARF_OFS_RES_LOW);

	////////////////////////////////////////////////////////////////////////////
	// submodules
	// route buffer locks while busy so a mid-conversion write waits for completion
	arf_route_buffer u_route (
		.clock(clock),
		.rst(rst),
		.written(written_route),
		.lock(state == ARF_BUSY),
		.active(active_route)
	);

	// alignment read live from the select register, not from any snapshot
	arf_result_format u_format (
		.result(result),
		.left_align(conversion_input_select[ARF_ALIGN_BIT]),
		.data(data_word)
	);

	////////////////////////////////////////////////////////////////////////////
	// select and mask registers
	// the alignment bit is not buffered: it reaches the data word right after the write
	always_comb begin
		next_select = conversion_input_select;
		next_irq_mask = irq_mask;
		if (wr_en && (addr == ARF_OFS_SELECT)) begin
			next_select = pwdata[7:0];
		end
		if (wr_en && (addr == ARF_OFS_IRQ_MASK)) begin
			next_irq_mask = pwdata[ARF_IRQ_DONE_BIT:ARF_IRQ_DONE_BIT];
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			conversion_input_select <= ARF_SELECT_RESET;
			irq_mask <= ARF_IRQ_RESET;
		end else begin
			conversion_input_select <= next_select;
			irq_mask <= next_irq_mask;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// conversion sequencing
	// a start during a conversion is dropped; software polls the busy bit first
	always_comb begin
		next_state = state;
		next_conv_start = 1'b0;
		case (state)
			ARF_IDLE: begin
				if (start_req) begin
					next_state = ARF_BUSY;
					next_conv_start = 1'b1;
				end
			end
			ARF_BUSY: begin
				if (conv_done) begin
					next_state = ARF_IDLE;
				end
			end
			default: begin
				next_state = ARF_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state <= ARF_IDLE;
			conv_start <= 1'b0;
			// reset route is the select reset value without its alignment bit
			conv_route.reference_field <= ARF_SELECT_RESET[ARF_REF_MSB:ARF_REF_LSB];
			conv_route.channel_gain_field <= ARF_SELECT_RESET[ARF_CHAN_MSB:0];
		end else begin
			state <= next_state;
			conv_start <= next_conv_start;
			conv_route <= active_route;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// result hold: a low read locks, a high read releases and lands a pending result
	always_comb begin
		next_result = result;
		next_pending = pending;
		next_pending_valid = pending_valid;
		next_read_lock = read_lock;
		update_now = 1'b0;
		if (low_take) begin
			next_read_lock = 1'b1;
		end
		if (rd_en && (addr == ARF_OFS_RES_HIGH)) begin
			next_read_lock = 1'b0;
			if (pending_valid) begin
				next_result = pending;
				next_pending_valid = 1'b0;
				update_now = 1'b1;
			end
		end
		if (conv_done && (state == ARF_BUSY)) begin
			// parked results do not set the flag; it rises when the high read lands them
			if ((read_lock || low_take) && !(rd_en && (addr == ARF_OFS_RES_HIGH))) begin
				next_pending.diff = done_diff;
				next_pending.code = conv_code;
				next_pending_valid = 1'b1;
			end else begin
				next_result.diff = done_diff;
				next_result.code = conv_code;
				next_pending_valid = 1'b0;
				update_now = 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			result <= '0;
			pending <= '0;
			pending_valid <= 1'b0;
			read_lock <= 1'b0;
		end else begin
			result <= next_result;
			pending <= next_pending;
			pending_valid <= next_pending_valid;
			read_lock <= next_read_lock;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// completion flag: set with the result update, cleared by a status read, set wins
	// irq follows the status in the same cycle and the mask one cycle late; the output stays a plain flip-flop
	always_comb begin
		next_irq_status = irq_status;
		if (rd_en && (addr == ARF_OFS_IRQ_STAT)) begin
			next_irq_status = ARF_IRQ_RESET;
		end
		if (update_now) begin
			next_irq_status[ARF_IRQ_DONE_BIT] = 1'b1;
		end
		next_irq = |(next_irq_status & irq_mask);
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			irq_status <= ARF_IRQ_RESET;
			irq <= 1'b0;
		end else begin
			irq_status <= next_irq_status;
			irq <= next_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// bus answer: one wait cycle, error on an unmapped address
	// prdata keeps its last value between answers; a master must take it with pready only
	always_comb begin
		next_pready = psel && penable && !pready;
		next_pslverr = 1'b0;
		next_prdata = prdata;
		if (psel && penable && !pready) begin
			next_pslverr = !mapped;
			next_prdata = '0;
			case (addr)
				ARF_OFS_SELECT: begin
					next_prdata[7:0] = conversion_input_select;
				end
				ARF_OFS_CONTROL: begin
					next_prdata[ARF_CTRL_BUSY_BIT] = (state == ARF_BUSY);
				end
				ARF_OFS_RES_LOW: begin
					next_prdata[7:0] = data_word[7:0];
				end
				ARF_OFS_RES_HIGH: begin
					next_prdata[7:0] = data_word[ARF_DATA_W-1:8];
				end
				ARF_OFS_IRQ_STAT: begin
					next_prdata[ARF_IRQ_DONE_BIT] = irq_status[ARF_IRQ_DONE_BIT];
				end
				ARF_OFS_IRQ_MASK: begin
					next_prdata[ARF_IRQ_DONE_BIT] = irq_mask[ARF_IRQ_DONE_BIT];
				end
				default: begin
					next_prdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

endmodule

// file: tb/arf_core_model.sv
// partner: converter core behind the block
// the bench sets the next code and how long each conversion takes
`timescale 1ns/1ps
module arf_core_model (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// bench control
	input wire logic [9:0] code,
	input wire logic [7:0] delay,
	// core side of the block
	input wire logic conv_start,
	output logic conv_done,
	output logic [9:0] conv_code
);
	logic [7:0] cnt;
	logic [7:0] next_cnt;
	logic [9:0] held;
	logic [9:0] next_held;

	////////////////////////////////////////////////////////////////////////////
	// countdown from start to done; code captured at start
	always_comb begin
		next_cnt = cnt;
		next_held = held;
		if (conv_start) begin
			next_cnt = delay;
			next_held = code;
		end else if (cnt != 8'h00) begin
			next_cnt = cnt - 8'h01;
		end
	end
	always_ff @(posedge clock) begin
		if (rst) begin
			cnt <= 8'h00;
			held <= 10'h000;
		end else begin
			cnt <= next_cnt;
			held <= next_held;
		end
	end
	// inverse outside the valid cycle so no stale match; quiet mid-conversion
	assign conv_done = (cnt == 8'h01);
	assign conv_code = conv_done ? held : ~held;
endmodule

// file: tb/arf_converter_ctrl_sva.sv
// checker for the converter control top
// sees the top ports only; bound after the module
`timescale 1ns/1ps
module arf_converter_ctrl_chk import arf_pkg::*; #(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// core and interrupt
	input wire logic conv_start,
	input wire arf_route_s conv_route,
	input wire logic conv_done,
	input wire logic [ARF_RES_W-1:0] conv_code,
	input wire logic irq
);
	logic busy;
	logic next_busy;
	logic [7:0] sel;
	logic [7:0] next_sel;
	logic wr_ok;
	logic map;
	assign wr_ok = psel && penable && pready && pwrite;
	assign map = paddr inside {12'h07C, 12'h080, 12'h084, 12'h088, 12'h08C, 12'h090};

	////////////////////////////////////////////////////////////////////////////
	// shadow of conversion state and select register
	always_comb begin
		next_busy = conv_start ? 1'b1 : (conv_done ? 1'b0 : busy);
		next_sel = (wr_ok && paddr == ARF_OFS_SELECT) ? pwdata[7:0] : sel;
	end
	always_ff @(posedge clock) begin
		if (rst) begin
			busy <= 1'b0;
			sel <= 8'h00;
		end else begin
			busy <= next_busy;
			sel <= next_sel;
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	a_route_frozen: assert property (busy && !conv_done |=> $stable(conv_route))
		else $error("route moved mid conversion");
	a_ready_wait: assert property ($rose(penable) && psel |=> pready)
		else $error("no ready in second access cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_err_unmapped: assert property (pready && !map |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_err_mapped: assert property (pready && map |-> !pslverr)
		else $error("mapped access refused");
	a_select_read: assert property (pready && !pwrite && paddr == ARF_OFS_SELECT |-> prdata == {24'h0, sel})
		else $error("select readback wrong");
	a_start_launch: assert property (wr_ok && paddr == ARF_OFS_CONTROL && pwdata[0] && !busy |=> conv_start)
		else $error("start not launched");
	a_start_once: assert property (busy |-> !conv_start)
		else $error("start while busy");
	a_high_zero: assert property (pready && !pwrite && paddr inside {12'h084, 12'h088} |-> prdata[31:8] == 24'h0)
		else $error("result upper bits set");

	c_done: cover property (conv_done);
	c_err: cover property (pready && pslverr);
	c_irq: cover property ($rose(irq));
endmodule

bind arf_converter_ctrl arf_converter_ctrl_chk #(.ADDR_W(ADDR_W)) u_chk (
	.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.conv_start(conv_start), .conv_route(conv_route), .conv_done(conv_done),
	.conv_code(conv_code), .irq(irq)
);

// file: tb/test_adc_result_format_and_ref_select.sv
// self-checking bench for the converter control top
// drives apb, runs the core model, predicts result words
`timescale 1ns/1ps
module test_adc_result_format_and_ref_select import arf_pkg::*;;
	logic clock, rst, psel, penable, pwrite, pready, pslverr, conv_start, conv_done, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [9:0] conv_code, code;
	logic [7:0] delay;
	arf_route_s conv_route;
	logic [31:0] exp_q[$];
	int n_errors, cmp_count;

	arf_converter_ctrl #(.ADDR_W(12)) dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .conv_start(conv_start), .conv_route(conv_route), .conv_done(conv_done),
		.conv_code(conv_code), .irq(irq));
	arf_core_model u_core (.clock(clock), .rst(rst), .code(code), .delay(delay),
		.conv_start(conv_start), .conv_done(conv_done), .conv_code(conv_code));

	////////////////////////////////////////////////////////////////////////////
	task results;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task chk_reg(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task chk_route(input arf_route_s got, input arf_route_s exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one apb transfer; request held until ready is sampled
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			n_errors++;
			results;
		end
		rdat = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk_reg(rdat, e);
	endtask
	task automatic wait_hi(ref logic s);
		int n;
		n = 0;
		while (s !== 1'b1 && n < 200) begin
			@(posedge clock);
			n++;
		end
		if (n >= 200) begin
			n_errors++;
			results;
		end
	endtask
	// reference model: pairs flip msb to two's complement, then align
	function logic [31:0] fmt(input logic [9:0] c, input logic df, input logic lf);
		logic [31:0] v;
		v = {22'h0, c ^ {df, 9'h0}};
		return lf ? v << 6 : v;
	endfunction

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	initial begin
		logic [7:0] s;
		logic [4:0] ch;
		logic [1:0] rf;
		logic [9:0] c;
		logic df, al;
		logic [31:0] d;
		rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
		code = 10'h000; delay = 8'h01; n_errors = 0; cmp_count = 0;
		void'($urandom(13));
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		rd(ARF_OFS_SELECT, 32'h0);
		rd(ARF_OFS_IRQ_MASK, 32'h0);
		s = 8'($urandom);
		wr(ARF_OFS_SELECT, {24'($urandom), s});
		rd(ARF_OFS_SELECT, {24'h0, s});
		apb(1'b0, 12'h0F0, 32'h0);
		chk_reg({31'h0, pslverr}, 32'h1);
		chk_reg(rdat, 32'h0);
		// all references single ended, then pairs with boundary codes
		for (int i = 0; i < 8; i++) begin
			df = (i >= 4);
			rf = df ? 2'h3 : 2'(i % 4);
			ch = df ? 5'h08 + 5'($urandom % 22) : (i == 3) ? 5'h1E : 5'($urandom % 8);
			al = 1'($urandom);
			s = {rf, al, ch};
			c = (i % 4 == 0) ? 10'h000 : (i % 4 == 1) ? 10'h3FF : 10'($urandom);
			code <= c;
			delay <= 8'(15 + $urandom % 30);
			wr(ARF_OFS_SELECT, {24'h0, s});
			wr(ARF_OFS_IRQ_MASK, 32'h1);
			wr(ARF_OFS_CONTROL, 32'h1);
			rd(ARF_OFS_CONTROL, 32'h2);
			wr(ARF_OFS_SELECT, {24'h0, s ^ 8'hC0});
			chk_route(conv_route, {s[7:6], s[4:0]});
			wait_hi(irq);
			repeat (3) @(posedge clock);
			chk_route(conv_route, {~s[7:6], s[4:0]});
			rd(ARF_OFS_IRQ_STAT, 32'h1);
			rd(ARF_OFS_IRQ_STAT, 32'h0);
			d = fmt(c, df, al);
			rd(ARF_OFS_RES_LOW, d & 32'hFF);
			rd(ARF_OFS_RES_HIGH, d >> 8);
			wr(ARF_OFS_SELECT, {24'h0, s ^ 8'hE0});
			d = fmt(c, df, ~al);
			rd(ARF_OFS_RES_LOW, d & 32'hFF);
			rd(ARF_OFS_RES_HIGH, d >> 8);
			chk_reg({31'h0, irq}, 32'h0);
		end
		// low read parks the next result until the high read
		wr(ARF_OFS_SELECT, 32'h40);
		wr(ARF_OFS_IRQ_MASK, 32'h0);
		code <= 10'h1C3;
		wr(ARF_OFS_CONTROL, 32'h1);
		wait_hi(conv_done);
		exp_q.push_back(fmt(10'h1C3, 1'b0, 1'b0));
		rd(ARF_OFS_RES_LOW, exp_q[0] & 32'hFF);
		rd(ARF_OFS_IRQ_STAT, 32'h1);
		code <= 10'h2A5;
		wr(ARF_OFS_CONTROL, 32'h1);
		wait_hi(conv_done);
		repeat (2) @(posedge clock);
		rd(ARF_OFS_IRQ_STAT, 32'h0);
		exp_q.push_back(fmt(10'h2A5, 1'b0, 1'b0));
		rd(ARF_OFS_RES_HIGH, exp_q.pop_front() >> 8);
		rd(ARF_OFS_RES_LOW, exp_q[0] & 32'hFF);
		rd(ARF_OFS_RES_HIGH, exp_q.pop_front() >> 8);
		rd(ARF_OFS_IRQ_STAT, 32'h1);
		chk_reg({31'h0, irq}, 32'h0);
		results;
	end
endmodule
